// file: include/crsu_consts.svh
// Constants of the CPU register and stack unit: addresses, field positions and widths.
// Assumes a 12-bit data memory address whose top four bits are the memory bank.
`ifndef CRSU_CONSTS_SVH
`define CRSU_CONSTS_SVH

`define CRSU_ADDR_W 12
`define CRSU_SP_ADDR 12'hF80
`define CRSU_SBS_ADDR 12'hF84
`define CRSU_PSW_LO_ADDR 12'hFB0
`define CRSU_PSW_HI_ADDR 12'hFB1
`define CRSU_PERI_BASE 12'hF80
`define CRSU_PERI_TOP 12'hFFF
`define CRSU_GREG_TOP 12'h01F
`define CRSU_NUM_BANKS 4
`define CRSU_REGS_PER_BANK 8
`define CRSU_NUM_REGS 32
`define CRSU_SBS_RESET 4'h0
`define CRSU_SP_RESET 8'h00
`define CRSU_CY_RESET 1'b0
`define CRSU_PSW_RESET 8'h00
`define CRSU_PSW_RBE 0
`define CRSU_PSW_MBE 1
`define CRSU_PSW_IST0 2
`define CRSU_PSW_IST1 3
`define CRSU_PSW_SK0 4
`define CRSU_PSW_CY 7
`define CRSU_CALL_MASK 8'h03
`define CRSU_REG_A 3'h0
`define CRSU_REG_X 3'h1
`define CRSU_REG_L 3'h2
`define CRSU_REG_H 3'h3
`define CRSU_REG_E 3'h4
`define CRSU_REG_D 3'h5

`endif

// file: include/crsu_pkg.sv
// Types shared by the register and stack unit and its stack pointer module.
// Assumes crsu_consts.svh supplies the numeric constants.
package crsu_pkg;
	// Four-state base types let these enums travel on wire ports.
	typedef enum logic [3:0] {
		CRSU_CY_NONE,
		CRSU_CY_SET,
		CRSU_CY_CLR,
		CRSU_CY_INV,
		CRSU_CY_LOAD,
		CRSU_CY_AND,
		CRSU_CY_OR,
		CRSU_CY_XOR,
		CRSU_CY_ARITH
	} crsu_cy_op_e;
	typedef enum logic [2:0] {
		CRSU_PSW_NONE,
		CRSU_PSW_CALL,
		CRSU_PSW_IRQ,
		CRSU_PSW_RET,
		CRSU_PSW_RETURN_FROM_INTERRUPT
	} crsu_psw_op_e;
	typedef logic [3:0] crsu_nib_t;
endpackage : crsu_pkg

// file: include/crsu_stk_if.sv
// Carrier between the register unit and its stack pointer module.
// Assumes one clock domain; the register unit drives the requests.
`timescale 1ns/1ps
interface crsu_stk_if;
	logic push;
	logic pop;
	logic sp_wr;
	logic [7:0] sp_wdata;
	logic sbs_wr;
	logic [3:0] sbs_wdata;
	logic [7:0] sp;
	logic [3:0] stack_bank_choice;
	logic [9:0] addr;
	modport ctrl (output push, pop, sp_wr, sp_wdata, sbs_wr, sbs_wdata, input sp, stack_bank_choice, addr);
	modport stk (input push, pop, sp_wr, sp_wdata, sbs_wr, sbs_wdata, output sp, stack_bank_choice, addr);
endinterface : crsu_stk_if

// file: rtl/crsu_stack_ptr.sv
// Stack pointer and stack bank selection with stack RAM address forming.
// Assumes push and pop are never requested in the same cycle.
`timescale 1ns/1ps
`include "crsu_consts.svh"
module crsu_stack_ptr
	import crsu_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	crsu_stk_if.stk stk_if
);
	logic [7:0] stack_ptr_ff;
	logic [7:0] nxt_stack_ptr;
	logic [1:0] stack_bank_sel_ff;

	// Reset value is arbitrary: software must load both before stacking.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stack_ptr_ff <= `CRSU_SP_RESET;
		end else begin
			stack_ptr_ff <= nxt_stack_ptr;
		end
	end

	always_comb begin
		nxt_stack_ptr = stack_ptr_ff;
		if (stk_if.sp_wr) begin
			nxt_stack_ptr = {stk_if.sp_wdata[7:1], 1'b0};
		end else if (stk_if.push) begin
			// Eight-bit wrap keeps the stack inside its bank.
			nxt_stack_ptr = stack_ptr_ff - 8'h01;
		end else if (stk_if.pop) begin
			nxt_stack_ptr = stack_ptr_ff + 8'h01;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stack_bank_sel_ff <= 2'(`CRSU_SBS_RESET);
		end else if (stk_if.sbs_wr) begin
			stack_bank_sel_ff <= stk_if.sbs_wdata[1:0];
		end
	end

	// Push addresses the decremented pointer, pop the current one.
	assign stk_if.addr = {stack_bank_sel_ff, (stk_if.push ? stack_ptr_ff - 8'h01 : stack_ptr_ff)};
	assign stk_if.sp = stack_ptr_ff;
	assign stk_if.stack_bank_choice = {2'b00, stack_bank_sel_ff};
endmodule : crsu_stack_ptr

// file: rtl/crsu_reg_unit.sv
// Register and stack unit of the 4-bit CPU: general registers, accumulators,
// carry and status word, stack pointer, and the memory-mapped view of them.
// Assumes the execution core issues at most one operation per port per cycle.
`timescale 1ns/1ps
`include "crsu_consts.svh"

module crsu_reg_unit
	import crsu_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic [1:0] reg_bank_choice_in,
	input wire logic [2:0] rg_sel_in,
	input wire logic rg_pair_in,
	input wire logic rg_wr_in,
	input wire logic [7:0] rg_wdata_in,
	output logic [7:0] rg_rdata_out,
	output logic [3:0] acc4_out,
	output logic [7:0] acc8_out,
	output logic [7:0] hl_ptr_out,
	output logic [7:0] de_ptr_out,
	output logic [7:0] dl_ptr_out,
	input wire logic dm_rd_in,
	input wire logic dm_wr_in,
	input wire logic dm_wide_in,
	input wire logic [11:0] dm_addr_in,
	input wire logic [7:0] dm_wdata_in,
	output logic [7:0] dm_rdata_out,
	output logic dm_hit_out,
	input wire logic stk_push_in,
	input wire logic stk_pop_in,
	input wire logic [3:0] stk_wdata_in,
	output logic [3:0] stk_rdata_out,
	output logic [9:0] ram_addr_out,
	output logic ram_we_out,
	output logic ram_re_out,
	output logic [3:0] ram_wdata_out,
	input wire logic [3:0] ram_rdata_in,
	input wire crsu_cy_op_e cy_op_in,
	input wire logic cy_bit_in,
	input wire logic cy_arith_in,
	output logic carry_out,
	output logic cy_skip_out,
	input wire logic skip_upd_in,
	input wire logic [2:0] skip_state_in,
	input wire crsu_psw_op_e psw_op_in,
	input wire logic [7:0] psw_restore_in,
	output logic [7:0] psw_save_out,
	output logic [7:0] status_word_out,
	output logic [1:0] active_bank_out
);
	crsu_nib_t greg_ff [`CRSU_NUM_REGS];
	crsu_nib_t nxt_greg [`CRSU_NUM_REGS];
	logic carry_bit_ff;
	logic nxt_carry_bit;
	logic [6:0] status_ff;
	logic [6:0] nxt_status;
	logic [7:0] status_word;
	logic [7:0] dm_rdata_ff;
	logic [7:0] nxt_dm_rdata;
	logic dm_hit;
	logic [3:0] stk_rdata_ff;
	logic [4:0] rg_idx;
	logic stk_in_greg;
	logic [4:0] stk_idx;
	logic [4:0] dm_idx;
	crsu_stk_if stk_if ();

	// Index of a register inside the flat array from bank and register number.
	function automatic logic [4:0] greg_index(input logic [1:0] bank, input logic [2:0] sel);
		greg_index = {bank, sel};
	endfunction : greg_index

	// True when a 12-bit data address lands in the general register area.
	function automatic logic in_greg_area(input logic [11:0] addr);
		in_greg_area = (addr <= `CRSU_GREG_TOP);
	endfunction : in_greg_area

	assign active_bank_out = reg_bank_choice_in & {2{status_ff[`CRSU_PSW_RBE]}};
	assign rg_idx = greg_index(active_bank_out, rg_sel_in);

	crsu_stack_ptr u_stack_ptr (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.stk_if(stk_if.stk)
	);

	assign stk_if.push = stk_push_in;
	assign stk_if.pop = stk_pop_in && !stk_push_in;
	assign stk_if.sp_wr = dm_wr_in && dm_wide_in && (dm_addr_in == `CRSU_SP_ADDR);
	assign stk_if.sp_wdata = dm_wdata_in;
	assign stk_if.sbs_wr = dm_wr_in && !dm_wide_in && (dm_addr_in == `CRSU_SBS_ADDR);
	assign stk_if.sbs_wdata = dm_wdata_in[3:0];

	// Stack traffic that lands on unused general registers is kept here.
	assign stk_in_greg = in_greg_area({2'b00, stk_if.addr});
	assign stk_idx = stk_if.addr[4:0];
	assign dm_idx = dm_addr_in[4:0];
	assign ram_addr_out = stk_if.addr;
	assign ram_we_out = stk_push_in && !stk_in_greg;
	assign ram_re_out = stk_if.pop && !stk_in_greg;
	assign ram_wdata_out = stk_wdata_in;

	// Priority is register port, then memory port, then stack push, on the same nibble.
	always_comb begin
		for (int i = 0; i < `CRSU_NUM_REGS; i++) begin
			nxt_greg[i] = greg_ff[i];
		end
		if (stk_push_in && stk_in_greg) begin
			nxt_greg[stk_idx] = stk_wdata_in;
		end
		if (dm_wr_in && in_greg_area(dm_addr_in)) begin
			nxt_greg[dm_idx] = dm_wdata_in[3:0];
			if (dm_wide_in) begin
				nxt_greg[{dm_idx[4:1], 1'b1}] = dm_wdata_in[7:4];
				nxt_greg[{dm_idx[4:1], 1'b0}] = dm_wdata_in[3:0];
			end
		end
		if (rg_wr_in) begin
			if (rg_pair_in) begin
				nxt_greg[{rg_idx[4:1], 1'b1}] = rg_wdata_in[7:4];
				nxt_greg[{rg_idx[4:1], 1'b0}] = rg_wdata_in[3:0];
			end else begin
				nxt_greg[rg_idx] = rg_wdata_in[3:0];
			end
		end
	end

	generate
		for (genvar g = 0; g < `CRSU_NUM_REGS; g++) begin : g_greg
			always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					greg_ff[g] <= 4'h0;
				end else begin
					greg_ff[g] <= nxt_greg[g];
				end
			end
		end
	endgenerate

	always_comb begin
		if (rg_pair_in) begin
			rg_rdata_out = {greg_ff[{rg_idx[4:1], 1'b1}], greg_ff[{rg_idx[4:1], 1'b0}]};
		end else begin
			rg_rdata_out = {4'h0, greg_ff[rg_idx]};
		end
	end

	assign acc4_out = greg_ff[greg_index(active_bank_out, `CRSU_REG_A)];
	assign acc8_out = {greg_ff[greg_index(active_bank_out, `CRSU_REG_X)], acc4_out};
	assign hl_ptr_out = {greg_ff[greg_index(active_bank_out, `CRSU_REG_H)],
		greg_ff[greg_index(active_bank_out, `CRSU_REG_L)]};
	assign de_ptr_out = {greg_ff[greg_index(active_bank_out, `CRSU_REG_D)],
		greg_ff[greg_index(active_bank_out, `CRSU_REG_E)]};
	assign dl_ptr_out = {greg_ff[greg_index(active_bank_out, `CRSU_REG_D)],
		greg_ff[greg_index(active_bank_out, `CRSU_REG_L)]};

	// Carry has no memory-mapped write path; only its own operations and an interrupt return change it.
	always_comb begin
		nxt_carry_bit = carry_bit_ff;
		case (cy_op_in)
			CRSU_CY_NONE: nxt_carry_bit = carry_bit_ff;
			CRSU_CY_SET: nxt_carry_bit = 1'b1;
			CRSU_CY_CLR: nxt_carry_bit = 1'b0;
			CRSU_CY_INV: nxt_carry_bit = !carry_bit_ff;
			CRSU_CY_LOAD: nxt_carry_bit = cy_bit_in;
			CRSU_CY_AND: nxt_carry_bit = carry_bit_ff & cy_bit_in;
			CRSU_CY_OR: nxt_carry_bit = carry_bit_ff | cy_bit_in;
			CRSU_CY_XOR: nxt_carry_bit = carry_bit_ff ^ cy_bit_in;
			CRSU_CY_ARITH: nxt_carry_bit = cy_arith_in;
			default: nxt_carry_bit = carry_bit_ff;
		endcase
		if (psw_op_in == CRSU_PSW_RETURN_FROM_INTERRUPT) begin
			nxt_carry_bit = psw_restore_in[`CRSU_PSW_CY];
		end
	end

	// Any reset value is legal because carry is undefined after reset.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			carry_bit_ff <= `CRSU_CY_RESET;
		end else begin
			carry_bit_ff <= nxt_carry_bit;
		end
	end

	assign carry_out = carry_bit_ff;
	assign cy_skip_out = carry_bit_ff;

	// Status bits 6..0: skip flags in 6..4, interrupt status and expand flags in 3..0.
	always_comb begin
		nxt_status = status_ff;
		if (skip_upd_in) begin
			nxt_status[6:4] = skip_state_in;
		end
		if (dm_wr_in && !dm_wide_in && (dm_addr_in == `CRSU_PSW_LO_ADDR)) begin
			nxt_status[3:0] = dm_wdata_in[3:0];
		end
		case (psw_op_in)
			CRSU_PSW_RET: nxt_status[1:0] = psw_restore_in[1:0];
			CRSU_PSW_RETURN_FROM_INTERRUPT: nxt_status = psw_restore_in[6:0];
			default: nxt_status = nxt_status;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			status_ff <= 7'(`CRSU_PSW_RESET);
		end else begin
			status_ff <= nxt_status;
		end
	end

	assign status_word = {carry_bit_ff, status_ff};
	assign status_word_out = status_word;

	// Calls expose only the two expand bits; interrupts expose the whole word.
	always_comb begin
		case (psw_op_in)
			CRSU_PSW_CALL: psw_save_out = status_word & `CRSU_CALL_MASK;
			CRSU_PSW_IRQ: psw_save_out = status_word;
			default: psw_save_out = status_word;
		endcase
	end

	// Memory-mapped read; unassigned bank-15 locations answer zero and store nothing.
	always_comb begin
		nxt_dm_rdata = 8'h00;
		dm_hit = 1'b0;
		if (in_greg_area(dm_addr_in)) begin
			dm_hit = 1'b1;
			if (dm_wide_in) begin
				nxt_dm_rdata = {greg_ff[{dm_idx[4:1], 1'b1}], greg_ff[{dm_idx[4:1], 1'b0}]};
			end else begin
				nxt_dm_rdata = {4'h0, greg_ff[dm_idx]};
			end
		end else if (dm_addr_in >= `CRSU_PERI_BASE) begin
			dm_hit = 1'b1;
			case (dm_addr_in)
				`CRSU_SP_ADDR: nxt_dm_rdata = {stk_if.sp[7:1], 1'b0};
				`CRSU_SBS_ADDR: nxt_dm_rdata = {4'h0, stk_if.stack_bank_choice};
				`CRSU_PSW_LO_ADDR: nxt_dm_rdata = {4'h0, status_word[3:0]};
				`CRSU_PSW_HI_ADDR: nxt_dm_rdata = {4'h0, status_word[7:4]};
				default: nxt_dm_rdata = 8'h00;
			endcase
		end
	end

	assign dm_hit_out = dm_hit;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dm_rdata_ff <= 8'h00;
		end else if (dm_rd_in) begin
			dm_rdata_ff <= nxt_dm_rdata;
		end
	end

	assign dm_rdata_out = dm_rdata_ff;

	// Popped nibble from registers or external RAM, registered for the core.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stk_rdata_ff <= 4'h0;
		end else if (stk_if.pop) begin
			stk_rdata_ff <= stk_in_greg ? greg_ff[stk_idx] : ram_rdata_in;
		end
	end

	assign stk_rdata_out = stk_rdata_ff;
endmodule : crsu_reg_unit

// file: testbench/crsu_reg_unit_monitor.sv
// Concurrent checks on the ports of the register and stack unit.
// Assumes one clock domain and is attached by bind from the testbench.
`timescale 1ns/1ps
module crsu_reg_unit_monitor
	import crsu_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic [1:0] reg_bank_choice_in,
	input wire logic dm_rd_in,
	input wire logic dm_wr_in,
	input wire logic [11:0] dm_addr_in,
	input wire logic [7:0] dm_rdata_out,
	input wire logic dm_hit_out,
	input wire logic stk_push_in,
	input wire logic stk_pop_in,
	input wire logic [9:0] ram_addr_out,
	input wire logic ram_we_out,
	input wire crsu_cy_op_e cy_op_in,
	input wire logic carry_out,
	input wire logic skip_upd_in,
	input wire logic [2:0] skip_state_in,
	input wire crsu_psw_op_e psw_op_in,
	input wire logic [7:0] psw_restore_in,
	input wire logic [7:0] psw_save_out,
	input wire logic [7:0] status_word_out,
	input wire logic [1:0] active_bank_out,
	input wire logic [3:0] acc4_out,
	input wire logic [7:0] acc8_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	// A memory write in the same cycle may override the pointer, so those cycles are excluded.
	sequence s_push;
		stk_push_in && !dm_wr_in;
	endsequence
	sequence s_pop;
		stk_pop_in && !stk_push_in && !dm_wr_in;
	endsequence
	AST_PUSH_POP: assert property (s_push ##1 s_pop |-> ram_addr_out == $past(ram_addr_out))
		else $error("pop address differs from last push address");
	AST_PUSH_PUSH: assert property (s_push ##1 s_push |->
		ram_addr_out == {$past(ram_addr_out[9:8]), $past(ram_addr_out[7:0]) - 8'h01})
		else $error("second push not one below first in same bank");
	AST_PUSH_WE: assert property (stk_push_in && ram_addr_out > 10'h01F |-> ram_we_out)
		else $error("push to stack RAM without write enable");
	AST_SP_EVEN: assert property (dm_rd_in && dm_addr_in == 12'hF80 |=> dm_rdata_out[0] == 1'b0)
		else $error("stack pointer read is odd");
	AST_SBS_TOP: assert property (dm_rd_in && dm_addr_in == 12'hF84 |=> dm_rdata_out[7:2] == 6'h00)
		else $error("stack bank read upper bits not zero");
	AST_HIT: assert property (dm_hit_out == (dm_addr_in <= 12'h01F || dm_addr_in >= 12'hF80))
		else $error("address decode wrong");
	AST_BANK: assert property (active_bank_out == (reg_bank_choice_in & {2{status_word_out[0]}}))
		else $error("active bank not expand AND selector");
	AST_ACC: assert property (acc8_out[3:0] == acc4_out)
		else $error("byte accumulator low nibble differs from A");
	AST_CALL: assert property (psw_op_in == CRSU_PSW_CALL |-> psw_save_out == (status_word_out & 8'h03))
		else $error("call saves more than expand bits");
	AST_IRQ: assert property (psw_op_in == CRSU_PSW_IRQ |-> psw_save_out == status_word_out)
		else $error("interrupt save not whole word");
	AST_RETURN_FROM_INTERRUPT: assert property (psw_op_in == CRSU_PSW_RETURN_FROM_INTERRUPT |=> status_word_out == $past(psw_restore_in)
		&& carry_out == $past(psw_restore_in[7]))
		else $error("interrupt return did not restore whole word");
	AST_CY_HOLD: assert property (cy_op_in == CRSU_CY_NONE && psw_op_in != CRSU_PSW_RETURN_FROM_INTERRUPT |=> $stable(carry_out))
		else $error("carry changed without a carry operation");
	AST_SKIP: assert property (skip_upd_in && psw_op_in == CRSU_PSW_NONE |=>
		status_word_out[6:4] == $past(skip_state_in))
		else $error("skip flags not updated");
endmodule : crsu_reg_unit_monitor

// file: testbench/crsu_ram_model.sv
// Stack RAM on the far side of the unit: four banks of 256 nibbles.
// Assumes asynchronous read; an idle read port shows the inverse of the last value, never stale data.
`timescale 1ns/1ps
module crsu_ram_model (
	input wire logic ref_clk_in,
	input wire logic [9:0] ram_addr_in,
	input wire logic ram_we_in,
	input wire logic ram_re_in,
	input wire logic [3:0] ram_wdata_in,
	output logic [3:0] ram_rdata_out
);
	logic [3:0] mem_ff [1024];
	logic [3:0] last_ff;
	always_ff @(posedge ref_clk_in) begin
		if (ram_we_in) mem_ff[ram_addr_in] <= ram_wdata_in;
	end
	always_ff @(posedge ref_clk_in) begin
		if (ram_re_in) last_ff <= mem_ff[ram_addr_in];
	end
	assign ram_rdata_out = ram_re_in ? mem_ff[ram_addr_in] : ~last_ff;
endmodule : crsu_ram_model

// file: testbench/crsu_reg_unit_tb.sv
// Self-checking testbench of the register and stack unit with a stack RAM model.
// Assumes the monitor and RAM model files are compiled before this one.
`timescale 1ns/1ps
module crsu_reg_unit_tb
	import crsu_pkg::*;
;
	logic ref_clk_in, rst_b_in, rg_pair_in, rg_wr_in, dm_rd_in, dm_wr_in, dm_wide_in, stk_push_in, stk_pop_in;
	logic cy_bit_in, cy_arith_in, skip_upd_in, dm_hit_out, ram_we_out, ram_re_out, carry_out, cy_skip_out;
	logic [1:0] reg_bank_choice_in, active_bank_out;
	logic [2:0] rg_sel_in, skip_state_in;
	logic [3:0] stk_wdata_in, ram_rdata_in, acc4_out, stk_rdata_out, ram_wdata_out;
	logic [7:0] rg_wdata_in, dm_wdata_in, psw_restore_in, rg_rdata_out, acc8_out, hl_ptr_out, de_ptr_out;
	logic [7:0] dl_ptr_out, dm_rdata_out, psw_save_out, status_word_out, save_seen;
	logic [9:0] ram_addr_out, addr_seen;
	logic [11:0] dm_addr_in;
	crsu_cy_op_e cy_op_in;
	crsu_psw_op_e psw_op_in;
	int failures, tests_run, cycles;
	crsu_reg_unit crsu_reg_unit_inst(.ref_clk_in, .rst_b_in, .reg_bank_choice_in, .rg_sel_in, .rg_pair_in,
		.rg_wr_in, .rg_wdata_in, .rg_rdata_out, .acc4_out, .acc8_out, .hl_ptr_out, .de_ptr_out, .dl_ptr_out,
		.dm_rd_in, .dm_wr_in, .dm_wide_in, .dm_addr_in, .dm_wdata_in, .dm_rdata_out, .dm_hit_out, .stk_push_in,
		.stk_pop_in, .stk_wdata_in, .stk_rdata_out, .ram_addr_out, .ram_we_out, .ram_re_out, .ram_wdata_out,
		.ram_rdata_in, .cy_op_in, .cy_bit_in, .cy_arith_in, .carry_out, .cy_skip_out, .skip_upd_in,
		.skip_state_in, .psw_op_in, .psw_restore_in, .psw_save_out, .status_word_out, .active_bank_out);
	crsu_ram_model crsu_ram_model_inst(.ref_clk_in, .ram_addr_in(ram_addr_out), .ram_we_in(ram_we_out),
		.ram_re_in(ram_re_out), .ram_wdata_in(ram_wdata_out), .ram_rdata_out(ram_rdata_in));
	initial begin
		ref_clk_in = 1'b0;
		forever #25 ref_clk_in = ~ref_clk_in;
	end
	task chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	task mem(input logic wr, input logic wide, input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		dm_wr_in <= wr;
		dm_rd_in <= !wr;
		dm_wide_in <= wide;
		dm_addr_in <= a;
		dm_wdata_in <= d;
		@(posedge ref_clk_in);
		dm_wr_in <= 1'b0;
		dm_rd_in <= 1'b0;
		#1;
	endtask : mem
	task stk(input logic push, input logic [3:0] d);
		@(posedge ref_clk_in);
		stk_push_in <= push;
		stk_pop_in <= !push;
		stk_wdata_in <= d;
		#1;
		addr_seen = ram_addr_out;
		chk("ram strobe", 10'h001, push ? ram_we_out : ram_re_out);
		@(posedge ref_clk_in);
		stk_push_in <= 1'b0;
		stk_pop_in <= 1'b0;
		#1;
	endtask : stk
	task op(input crsu_cy_op_e c, input logic b, input crsu_psw_op_e p, input logic [7:0] r);
		@(posedge ref_clk_in);
		cy_op_in <= c;
		cy_bit_in <= b;
		cy_arith_in <= b;
		psw_op_in <= p;
		psw_restore_in <= r;
		#1;
		save_seen = psw_save_out;
		@(posedge ref_clk_in);
		cy_op_in <= CRSU_CY_NONE;
		psw_op_in <= CRSU_PSW_NONE;
		#1;
	endtask : op
	task t_regs;
		@(posedge ref_clk_in);
		rg_wr_in <= 1'b1;
		rg_pair_in <= 1'b1;
		rg_sel_in <= 3'h0;
		rg_wdata_in <= 8'h5A;
		@(posedge ref_clk_in);
		rg_sel_in <= 3'h2;
		rg_wdata_in <= 8'hC3;
		@(posedge ref_clk_in);
		rg_wr_in <= 1'b0;
		#1;
		chk("acc8", 10'h05A, acc8_out);
		chk("hl", 10'h0C3, hl_ptr_out);
		chk("pair read", 10'h0C3, rg_rdata_out);
		chk("acc4", 10'h00A, acc4_out);
		mem(1'b0, 1'b0, 12'h000, 8'h00);
		chk("reg as mem", 10'h00A, dm_rdata_out);
		mem(1'b1, 1'b0, 12'h003, 8'h09);
		chk("mem into reg", 10'h093, hl_ptr_out);
		mem(1'b1, 1'b1, 12'h004, 8'h9E);
		chk("de", 10'h09E, de_ptr_out);
		chk("dl", 10'h093, dl_ptr_out);
		$display("test regs done");
	endtask : t_regs
	task t_stack;
		mem(1'b1, 1'b0, 12'hF84, 8'h0E);
		mem(1'b1, 1'b1, 12'hF80, 8'h00);
		mem(1'b0, 1'b0, 12'hF84, 8'h00);
		chk("bank sel", 10'h002, dm_rdata_out);
		stk(1'b1, 4'h7);
		chk("push 1", 10'h2FF, addr_seen);
		stk(1'b1, 4'h5);
		chk("push 2", 10'h2FE, addr_seen);
		stk(1'b0, 4'h0);
		chk("pop 1", 10'h2FE, addr_seen);
		chk("pop data 1", 10'h005, stk_rdata_out);
		stk(1'b0, 4'h0);
		chk("pop data 2", 10'h007, stk_rdata_out);
		mem(1'b0, 1'b1, 12'hF80, 8'h00);
		chk("sp wrap", 10'h000, dm_rdata_out);
		mem(1'b1, 1'b1, 12'hF80, 8'h37);
		mem(1'b0, 1'b1, 12'hF80, 8'h00);
		chk("sp even", 10'h036, dm_rdata_out);
		mem(1'b0, 1'b0, 12'h100, 8'h00);
		chk("gap hit", 10'h000, dm_hit_out);
		mem(1'b1, 1'b0, 12'hFB1, 8'h0F);
		mem(1'b0, 1'b0, 12'hFB1, 8'h00);
		chk("status high", 10'h000, dm_rdata_out);
		$display("test stack done");
	endtask : t_stack
	task t_burst;
		mem(1'b1, 1'b0, 12'hF84, 8'h00);
		mem(1'b1, 1'b1, 12'hF80, 8'h02);
		@(posedge ref_clk_in);
		stk_push_in <= 1'b1;
		stk_wdata_in <= 4'hB;
		#1;
		chk("greg push addr", 10'h001, ram_addr_out);
		chk("greg push we", 10'h000, ram_we_out);
		@(posedge ref_clk_in);
		stk_wdata_in <= 4'hC;
		#1;
		chk("greg push 2 addr", 10'h000, ram_addr_out);
		@(posedge ref_clk_in);
		stk_push_in <= 1'b0;
		stk_pop_in <= 1'b1;
		#1;
		chk("stack in regs", 10'h0BC, acc8_out);
		chk("greg pop re", 10'h000, ram_re_out);
		@(posedge ref_clk_in);
		#1;
		chk("greg pop 1", 10'h00C, stk_rdata_out);
		@(posedge ref_clk_in);
		stk_pop_in <= 1'b0;
		#1;
		chk("greg pop 2", 10'h00B, stk_rdata_out);
		$display("test burst done");
	endtask : t_burst
	task t_carry;
		crsu_cy_op_e ops [8];
		ops = '{CRSU_CY_SET, CRSU_CY_CLR, CRSU_CY_INV, CRSU_CY_LOAD, CRSU_CY_OR, CRSU_CY_XOR, CRSU_CY_AND,
			CRSU_CY_ARITH};
		for (int i = 0; i < 8; i++) begin
			op(ops[i], 1'(8'hF0 >> i), CRSU_PSW_NONE, 8'h00);
			chk("carry", 10'((8'h95 >> i) & 8'h01), {9'h000, carry_out});
			chk("carry skip", 10'((8'h95 >> i) & 8'h01), {9'h000, cy_skip_out});
		end
		$display("test carry done");
	endtask : t_carry
	task t_status;
		mem(1'b1, 1'b0, 12'hFB0, 8'h03);
		@(posedge ref_clk_in);
		reg_bank_choice_in <= 2'h2;
		#1;
		chk("bank on", 10'h002, active_bank_out);
		@(posedge ref_clk_in);
		skip_upd_in <= 1'b1;
		skip_state_in <= 3'h5;
		@(posedge ref_clk_in);
		skip_upd_in <= 1'b0;
		op(CRSU_CY_NONE, 1'b0, CRSU_PSW_IRQ, 8'h00);
		chk("irq save", 10'h0D3, save_seen);
		op(CRSU_CY_NONE, 1'b0, CRSU_PSW_CALL, 8'h00);
		chk("call save", 10'h003, save_seen);
		op(CRSU_CY_NONE, 1'b0, CRSU_PSW_RET, 8'hFC);
		chk("ret", 10'h0D0, status_word_out);
		chk("bank off", 10'h000, active_bank_out);
		op(CRSU_CY_SET, 1'b0, CRSU_PSW_RETURN_FROM_INTERRUPT, 8'h2A);
		chk("return_from_interrupt", 10'h02A, status_word_out);
		$display("test status done");
	endtask : t_status
	always @(posedge ref_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		{rst_b_in, rg_pair_in, rg_wr_in, dm_rd_in, dm_wr_in, dm_wide_in, stk_push_in, stk_pop_in} = '0;
		{cy_bit_in, cy_arith_in, skip_upd_in, reg_bank_choice_in, rg_sel_in, skip_state_in, stk_wdata_in} = '0;
		{rg_wdata_in, dm_wdata_in, psw_restore_in, dm_addr_in} = '0;
		cy_op_in = CRSU_CY_NONE;
		psw_op_in = CRSU_PSW_NONE;
		failures = 0;
		tests_run = 0;
		cycles = 0;
		repeat (2) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		t_regs();
		t_stack();
		t_burst();
		t_carry();
		t_status();
		give_verdict();
	end
endmodule : crsu_reg_unit_tb
bind crsu_reg_unit crsu_reg_unit_monitor crsu_reg_unit_monitor_inst(.ref_clk_in, .rst_b_in, .reg_bank_choice_in,
	.dm_rd_in, .dm_wr_in, .dm_addr_in, .dm_rdata_out, .dm_hit_out, .stk_push_in, .stk_pop_in, .ram_addr_out,
	.ram_we_out, .cy_op_in, .carry_out, .skip_upd_in, .skip_state_in, .psw_op_in, .psw_restore_in,
	.psw_save_out, .status_word_out, .active_bank_out, .acc4_out, .acc8_out);
